//--- logic/eipc_pkg.sv
package eipc_pkg;

	// ==========================================================
	// pin population
	// ==========================================================
	localparam int NUM_PINS = 6;

	typedef enum logic [1:0] {
		EIPC_TYPE_A,
		EIPC_TYPE_B,
		EIPC_TYPE_C
	} eipc_pin_type_t;

	localparam int PIN_A_NMI  = 0;
	localparam int PIN_A_MASK = 1;
	localparam int PIN_B0     = 2;
	localparam int PIN_B1     = 3;
	localparam int PIN_C0     = 4;
	localparam int PIN_C1     = 5;

	localparam eipc_pin_type_t PIN_TYPE [NUM_PINS] = '{
		EIPC_TYPE_A, EIPC_TYPE_A, EIPC_TYPE_B, EIPC_TYPE_B, EIPC_TYPE_C, EIPC_TYPE_C
	};

	// ==========================================================
	// control register layout
	// ==========================================================
	localparam int CFG_W     = 6;
	localparam int FLAG_BIT  = 15;
	localparam int LEVEL_BIT = 6;
	localparam int NMI_BIT   = 5;
	localparam int DIR_BIT   = 4;
	localparam int DOUT_BIT  = 3;
	localparam int POL_BIT   = 2;
	localparam int PRIO_BIT  = 1;
	localparam int EN_BIT    = 0;

	localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
	localparam logic [CFG_W-1:0] WMASK_A   = 6'h07;
	localparam logic [CFG_W-1:0] WMASK_B   = 6'h3f;
	localparam logic [CFG_W-1:0] WMASK_C   = 6'h1f;
	localparam logic [CFG_W-1:0] FIXED_NMI = 6'h20;
	localparam logic [CFG_W-1:0] FIXED_NONE = 6'h00;

	// ==========================================================
	// bus map
	// ==========================================================
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] CTRL_STEP = 8'h04;
	localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h18;
	localparam logic [ADDR_W-1:0] MASK_OFS  = 8'h1c;
	localparam logic [1:0]  HRESP_OKAY = 2'h0;
	localparam int          HTRANS_ACTIVE_BIT = 1;

endpackage

//--- logic/eipc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RL1] flag sets on the programmed edge whether or not the pin is enabled
// [RL2] each programmed edge on an enabled pin raises a fresh request
// [RL3] clearing the flag also cancels that pin's pending request
// [RL4] flag clears only by software clear or reset; reads 0 after reset
// [RL5] writing 0 to the flag clears it; writing 1 leaves it alone
// [RL6] pin-level bit always returns the present pin level
// [RL7] input-only pins have a fixed nonmaskable select: one 1, one 0
// [RL8] programmable-nonmaskable pins have writable nonmaskable select, reset 0
// [RL9] edge select: 0 falling, 1 rising; resets to 0
// [RL10] request level: 0 high, 1 low; ignored when nonmaskable
// [RL11] enable permits maskable request; ignored when nonmaskable; resets 0
// [RL12] on I/O pins, direction 0 input, 1 output when interrupts disabled
// [RL13] output value drives the pin low on 0, high on 1
// [RL14] reserved bits read back undefined (zero here) and ignore writes
// [RL15] every pin is a digital input after reset
// [RL16] input-only pins have no direction or output value bits
// [RL17] maskable-only pins have bit 5 reserved and act as nonmaskable 0
// [RL18] two pins of each I/O type, one nonmaskable and one maskable input pin
// [RL19] a CPU acknowledge leaves the flag set
module eipc_top
	import eipc_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	// ahb-lite slave
	input  wire logic                hsel_i,
	input  wire logic [31:0]         haddr_i,
	input  wire logic [1:0]          htrans_i,
	input  wire logic                hwrite_i,
	input  wire logic [2:0]          hsize_i,
	input  wire logic [31:0]         hwdata_i,
	input  wire logic                hready_i,
	output logic      [31:0]         hrdata_o,
	output logic                     hreadyout_o,
	output logic      [1:0]          hresp_o,
	// external interrupt pins
	input  wire logic [NUM_PINS-1:0] pin_i,
	output logic      [NUM_PINS-1:0] pin_o,
	output logic      [NUM_PINS-1:0] pin_oe_o,
	// cpu request side
	input  wire logic [NUM_PINS-1:0] ack_i,
	output logic      [NUM_PINS-1:0] mask_req_o,
	output logic      [NUM_PINS-1:0] mask_req_low_o,
	output logic                     nmi_req_o,
	output logic                     irq_o
);

	// ==========================================================
	// helpers
	// ==========================================================
	// the pin population is fixed: one input-only nonmaskable pin, one input-only
	// maskable pin, then two pins of each I/O-capable type
	function automatic logic [CFG_W-1:0] wmask_of(input int idx);
		case (PIN_TYPE[idx]) // see [RL18]
			EIPC_TYPE_A: wmask_of = WMASK_A;
			EIPC_TYPE_B: wmask_of = WMASK_B;
			default:     wmask_of = WMASK_C;
		endcase
	endfunction

	function automatic logic [CFG_W-1:0] fixed_of(input int idx);
		fixed_of = (idx == PIN_A_NMI) ? FIXED_NMI : FIXED_NONE; // see [RL7] [RL17]
	endfunction

	function automatic logic [ADDR_W-1:0] ctrl_ofs(input int idx);
		ctrl_ofs = CTRL_BASE + CTRL_STEP * ADDR_W'(idx);
	endfunction

	// ==========================================================
	// bus address phase
	// ==========================================================
	logic              acc_ff;
	logic              wr_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic              addr_phase;

	assign addr_phase = hsel_i & hready_i & htrans_i[HTRANS_ACTIVE_BIT];

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_ff  <= 1'b0;
			wr_ff   <= 1'b0;
			addr_ff <= '0;
		end else if (hready_i) begin
			acc_ff  <= addr_phase;
			wr_ff   <= addr_phase & hwrite_i;
			addr_ff <= haddr_i[ADDR_W-1:0];
		end
	end

	// no wait states: every register is a flop, so the answer is ready
	assign hreadyout_o = 1'b1;
	assign hresp_o     = HRESP_OKAY;

	logic [NUM_PINS-1:0] ctrl_wr;
	logic                stat_wr;
	logic                mask_wr;

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			ctrl_wr[i] = wr_ff & (addr_ff == ctrl_ofs(i));
		end
		stat_wr = wr_ff & (addr_ff == STAT_OFS);
		mask_wr = wr_ff & (addr_ff == MASK_OFS);
	end

	// ==========================================================
	// pin sampling and edge detect
	// ==========================================================
	logic [NUM_PINS-1:0] lvl_ff;
	logic                primed_ff;
	logic [NUM_PINS-1:0] edge_hit;

	// the first sample after reset only primes the history, so a pin
	// that is already high cannot fake a rising edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lvl_ff    <= '0;
			primed_ff <= 1'b0;
		end else begin
			lvl_ff    <= pin_i;
			primed_ff <= 1'b1;
		end
	end

	logic [CFG_W-1:0] cfg_ff  [NUM_PINS];
	logic [CFG_W-1:0] cfg_eff [NUM_PINS];

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			cfg_eff[i] = (cfg_ff[i] & wmask_of(i)) | fixed_of(i); // see [RL14] [RL16]
			if (cfg_eff[i][POL_BIT]) begin
				edge_hit[i] = primed_ff & pin_i[i] & ~lvl_ff[i]; // see [RL9]
			end else begin
				edge_hit[i] = primed_ff & ~pin_i[i] & lvl_ff[i];
			end
		end
	end

	// ==========================================================
	// configuration bits
	// ==========================================================
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				cfg_ff[i] <= CFG_RESET; // see [RL8] [RL11] [RL15]
			end
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (ctrl_wr[i]) begin
					cfg_ff[i] <= hwdata_i[CFG_W-1:0] & wmask_of(i); // see [RL14]
				end
			end
		end
	end

	// ==========================================================
	// edge flags and pending requests
	// ==========================================================
	logic [NUM_PINS-1:0] flag_ff;
	logic [NUM_PINS-1:0] pend_ff;
	logic [NUM_PINS-1:0] flag_clr;
	logic [NUM_PINS-1:0] req_arm;
	logic [NUM_PINS-1:0] nmi_sel;

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			flag_clr[i] = ctrl_wr[i] & ~hwdata_i[FLAG_BIT]; // see [RL5]
			nmi_sel[i]  = cfg_eff[i][NMI_BIT];
			req_arm[i]  = nmi_sel[i] | cfg_eff[i][EN_BIT]; // see [RL11]
		end
	end

	// a new edge wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flag_ff <= '0; // see [RL4]
		end else begin
			flag_ff <= edge_hit | (flag_ff & ~flag_clr); // see [RL1] [RL19]
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= (edge_hit & req_arm) // see [RL2]
				| (pend_ff & ~flag_clr & ~ack_i); // see [RL3]
		end
	end

	assign mask_req_o     = pend_ff & ~nmi_sel;
	assign nmi_req_o      = |(pend_ff & nmi_sel);

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			mask_req_low_o[i] = cfg_eff[i][PRIO_BIT] & ~nmi_sel[i]; // see [RL10]
		end
	end

	// ==========================================================
	// pin drive
	// ==========================================================
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_o[i]    = cfg_eff[i][DOUT_BIT]; // see [RL13]
			pin_oe_o[i] = cfg_eff[i][DIR_BIT] & ~cfg_eff[i][EN_BIT] & ~nmi_sel[i]; // see [RL12]
		end
	end

	// ==========================================================
	// event status and mask
	// ==========================================================
	logic [NUM_PINS-1:0] stat_ff;
	logic [NUM_PINS-1:0] mask_ff;
	logic [NUM_PINS-1:0] stat_clr;

	assign stat_clr = stat_wr ? hwdata_i[NUM_PINS-1:0] : '0;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= edge_hit | (stat_ff & ~stat_clr);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mask_ff <= '0;
		end else if (mask_wr) begin
			mask_ff <= hwdata_i[NUM_PINS-1:0];
		end
	end

	assign irq_o = |(stat_ff & mask_ff);

	// ==========================================================
	// read data
	// ==========================================================
	always_comb begin
		hrdata_o = '0;
		if (acc_ff && !wr_ff) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (addr_ff == ctrl_ofs(i)) begin
					hrdata_o[CFG_W-1:0] = cfg_eff[i];
					hrdata_o[LEVEL_BIT] = lvl_ff[i]; // see [RL6]
					hrdata_o[FLAG_BIT]  = flag_ff[i];
				end
			end
			if (addr_ff == STAT_OFS) begin
				hrdata_o[NUM_PINS-1:0] = stat_ff;
			end
			if (addr_ff == MASK_OFS) begin
				hrdata_o[NUM_PINS-1:0] = mask_ff;
			end
		end
	end

endmodule
`default_nettype wire

//--- verif/eipc_pins.sv
`timescale 1ns/1ns
`default_nettype none
module eipc_pins (
	input  wire logic       clk_i,
	input  wire logic [5:0] ext_i,
	input  wire logic       ack_en_i,
	input  wire logic       slow_i,
	input  wire logic [5:0] drv_i,
	input  wire logic [5:0] oe_i,
	input  wire logic [5:0] req_i,
	output logic      [5:0] pin_o,
	output logic      [5:0] ack_o
);
	// ====
	// pin wire and cpu acknowledge
	logic [2:0] cnt_ff = 3'h0;
	logic [5:0] ack_ff = 6'h00;
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
	assign ack_o = ack_ff;
	// slow mode acks every eighth cycle only, like a busy cpu
	always_ff @(posedge clk_i) begin
		cnt_ff <= cnt_ff + 3'h1;
		ack_ff <= {6{ack_en_i & (!slow_i | &cnt_ff)}} & req_i & ~ack_ff;
	end
endmodule
`default_nettype wire

//--- verif/eipc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module eipc_top_chk
	import eipc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        hsel_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic [1:0]  hresp_o,
	input wire logic [5:0]  pin_i,
	input wire logic [5:0]  pin_o,
	input wire logic [5:0]  pin_oe_o,
	input wire logic [5:0]  ack_i,
	input wire logic [5:0]  mask_req_o,
	input wire logic [5:0]  mask_req_low_o,
	input wire logic        nmi_req_o,
	input wire logic        irq_o
);
	// ====
	// properties
	logic acc;
	assign acc = hsel_i && hready_i && htrans_i[1];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_bus_okay: assert property (hreadyout_o && hresp_o == HRESP_OKAY)
		else $error("bus answer not okay");
	a_ab_no_drive: assert property (pin_oe_o[1:0] == 2'h0)
		else $error("input-only pin driven");
	a_reset_quiet: assert property ($rose(nrst_i) |->
		(pin_oe_o == 6'h00 && mask_req_o == 6'h00 && !nmi_req_o && !irq_o) [*2])
		else $error("activity right after reset");
	a_pin_write_only: assert property (
		$changed({pin_o, pin_oe_o}) |-> $past(acc && hwrite_i, 2))
		else $error("pin drive changed without write");
	a_hrdata_idle: assert property (hrdata_o != 32'h0 |-> $past(acc && !hwrite_i))
		else $error("read data outside data phase");
	a_ack_drops: assert property (ack_i[4] && $stable(pin_i[4]) |=> !mask_req_o[4])
		else $error("request stays after ack");
	a_nmi_low_off: assert property (!mask_req_low_o[0] && !mask_req_o[0])
		else $error("nonmaskable pin gave maskable request");
	a_irq_cause: assert property ($rose(irq_o) |->
		$past(pin_i) != $past(pin_i, 2) || $past(acc && hwrite_i, 2))
		else $error("irq rose without cause");
	c_mask_req: cover property ($rose(mask_req_o[4]));
	c_nmi: cover property ($rose(nmi_req_o));
	c_irq: cover property ($rose(irq_o));
endmodule
bind eipc_top eipc_top_chk u_chk (.*);
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import eipc_pkg::*;
;
	localparam logic [5:0] WM [6] = '{WMASK_A, WMASK_A, WMASK_B, WMASK_B, WMASK_C, WMASK_C};
	logic        clk_i, nrst_i, hsel, hwrite, ack_en, slow, mw_v, armed, nmi, irq, hrdy;
	logic [1:0]  htrans, hresp;
	logic [7:0]  haddr, mw_a;
	logic [31:0] hwdata, hrdata, rd, mw_d, r;
	logic [5:0]  ext, pin, pin_o, pin_oe, ack, mreq, mlow, prv, flg, st, mk, pd, nm, cf [6];
	int          failures, comparisons, seed, cyc;
	assign nm = {2'h0, cf[3][5], cf[2][5], 2'h1};
	eipc_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i({24'h0, haddr}),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .pin_i(pin), .pin_o(pin_o),
		.pin_oe_o(pin_oe), .ack_i(ack), .mask_req_o(mreq), .mask_req_low_o(mlow),
		.nmi_req_o(nmi), .irq_o(irq));
	eipc_pins u_pins (.clk_i(clk_i), .ext_i(ext), .ack_en_i(ack_en), .slow_i(slow),
		.drv_i(pin_o), .oe_i(pin_oe), .req_i(mreq), .pin_o(pin), .ack_o(ack));
	// ====
	// reference model: an edge in the cycle of a clear wins
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{flg, st, mk, pd, armed} <= '0;
			cf <= '{default: 6'h00};
		end else begin
			armed <= 1'b1;
			prv <= pin;
			if (mw_v && mw_a == MASK_OFS) mk <= mw_d[5:0];
			for (int i = 0; i < 6; i++) begin
				logic w, e;
				w = mw_v && mw_a == 8'(4 * i);
				e = armed && pin[i] != prv[i] && pin[i] == cf[i][2];
				if (w) cf[i] <= mw_d[5:0] & WM[i];
				if (w && !mw_d[15]) {flg[i], pd[i]} <= 2'h0;
				if (mw_v && mw_a == STAT_OFS && mw_d[i]) st[i] <= 1'b0;
				if (ack[i]) pd[i] <= 1'b0;
				if (e) {flg[i], st[i]} <= 2'h3;
				if (e && (cf[i][0] | nm[i])) pd[i] <= 1'b1;
			end
		end
	end
	function automatic logic [31:0] ev(int i);
		if (i < 6)
			return {16'h0, flg[i], 8'h0, prv[i], cf[i] | (i == 0 ? FIXED_NMI : FIXED_NONE)};
		return i == 6 ? {26'h0, st} : i == 7 ? {26'h0, mk} : 32'h0;
	endfunction
	// ====
	// compares, bus and run control
	always @(negedge clk_i) begin
		logic [5:0] lo, oe, dq;
		for (int i = 0; i < 6; i++) begin
			lo[i] = cf[i][1] & ~nm[i];
			oe[i] = cf[i][4] & ~cf[i][0] & ~nm[i];
			dq[i] = cf[i][3];
		end
		if (nrst_i) chk_out({mreq, mlow, pin_oe, pin_o, nmi, irq},
			{pd & ~nm, lo, oe, dq, |(pd & nm), |(st & mk)});
	end
	task automatic chk_out(input logic [25:0] g, e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t outputs %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t read %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'h2};
		do @(posedge clk_i); while (!hrdy);
		{htrans, hwdata, mw_v, mw_a, mw_d} <= {2'h0, d, w, a, d};
		do @(posedge clk_i); while (!hrdy);
		rd = hrdata;
		mw_v <= 1'b0;
	endtask
	task automatic rdchk(input int i);
		bus(1'b0, 8'(4 * i), 32'h0);
		cmp(rd, ev(i));
	endtask
	task automatic pulse(input logic [5:0] m);
		ext <= m;
		repeat (2) @(posedge clk_i);
		ext <= 6'h00;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		{nrst_i, hsel, hwrite, htrans, haddr, hwdata, mw_v, mw_a, mw_d, ext, ack_en, slow} = '0;
		seed = 51;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 9; i++) rdchk(i);
		bus(1'b1, MASK_OFS, 32'h3f);
		bus(1'b1, 8'h08, 32'h20);
		bus(1'b1, 8'h10, 32'h07);
		bus(1'b1, 8'h14, 32'h18);
		pulse(6'h15);
		pulse(6'h15);
		for (int i = 0; i < 7; i++) rdchk(i);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h08, 32'h20);
		bus(1'b1, 8'h10, 32'h8007);
		bus(1'b1, 8'h10, 32'h07);
		bus(1'b1, STAT_OFS, 32'h3f);
		ack_en <= 1'b1;
		pulse(6'h10);
		for (int i = 0; i < 7; i++) rdchk(i);
		slow <= 1'b1;
		repeat (80) begin
			r = $random(seed);
			ext <= r[13:8];
			if (r[0]) bus(1'b1, 8'(4 * (r[19:16] % 9)), $random(seed));
			else rdchk(r[19:16] % 9);
		end
		nrst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 8; i++) rdchk(i);
		stop_test();
	end
endmodule
`default_nettype wire
